// File: logic/motor_switch.sv
// two motors on one drive: selection, direction control, alarms, axi-lite config
`timescale 1ns/10ps
`default_nettype none
`include "motor_switch_cfg.svh"

module motor_switch #(
  parameter int unsigned TICK_CYCLES = `CLK_HZ * `TICK_S,
  parameter int unsigned ADDR_W      = 8
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [ADDR_W-1:0]          s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire motor_switch_pkg::cmd_t     cmd,
  input  wire motor_switch_pkg::field_in_t field_in,
  output var motor_switch_pkg::field_out_t field_out,
  output var motor_switch_pkg::status_t   status
);

  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("TICK_CYCLES must be at least 1");
  end
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  motor_switch_pkg::state_t state_q;
  motor_switch_pkg::state_t state_d;
  motor_switch_pkg::op_t    op;
  motor_switch_pkg::dir_t   jog;
  motor_switch_pkg::dir_t   want;
  logic                     tick;
  logic                     running;
  logic                     linked;
  logic                     blocked;
  logic                     fast_req;
  logic                     aw_fire;
  logic                     w_fire;
  logic                     ar_fire;
  logic [7:0]               wr_addr;
  logic [31:0]              wr_data;
  logic [3:0]               wr_strb;

  assign s_axi_awready = !state_q.aw_hold && !state_q.bvalid;
  assign s_axi_wready  = !state_q.w_hold && !state_q.bvalid;
  assign s_axi_arready = !state_q.rvalid;
  assign s_axi_bvalid  = state_q.bvalid;
  assign s_axi_bresp   = state_q.bresp;
  assign s_axi_rvalid  = state_q.rvalid;
  assign s_axi_rdata   = state_q.rdata;
  assign s_axi_rresp   = state_q.rresp;
  assign field_out     = state_q.out;
  assign status        = state_q.st;

  always_comb begin
    state_d = state_q;
    // seconds tick from the system clock
    tick = (state_q.presc == 32'(TICK_CYCLES - 1));
    state_d.presc = tick ? 32'h0 : state_q.presc + 32'h1;

    // operation mode from the two selects
    unique case ({cmd.manual_op_select, cmd.auto_op_select})
      2'b01:   op = motor_switch_pkg::OP_AUTO;
      2'b10:   op = motor_switch_pkg::OP_MANUAL;
      2'b11:   op = motor_switch_pkg::OP_BAD;
      default: op = motor_switch_pkg::OP_LOCAL;
    endcase
    state_d.op = op;
    state_d.st.auto_active_flag = (op == motor_switch_pkg::OP_AUTO);
    state_d.st.manual_active_flag = (op == motor_switch_pkg::OP_MANUAL);
    state_d.st.local_active_flag = (op == motor_switch_pkg::OP_LOCAL);
    state_d.st.bad_op_selection_alarm = (op == motor_switch_pkg::OP_BAD);

    // motor selection step runs before the control step
    running = state_q.out.drive_forward_out || state_q.out.drive_reverse_out
              || field_in.drive_running_in;
    if (cmd.alarm_clear_cmd) begin
      state_d.st.first_motor_select_alarm = 1'b0;
      state_d.st.second_motor_select_alarm = 1'b0;
    end
    // set after clear so a same-cycle request is never lost
    if (cmd.first_motor_request && state_q.sel == motor_switch_pkg::SEL_SECOND)
      state_d.st.first_motor_select_alarm = 1'b1;
    if (cmd.second_motor_request && state_q.sel == motor_switch_pkg::SEL_FIRST)
      state_d.st.second_motor_select_alarm = 1'b1;
    // a running motor is never dropped off the drive
    if (!running && cmd.first_motor_request && !cmd.second_motor_request)
      state_d.sel = motor_switch_pkg::SEL_FIRST;
    else if (!running && cmd.second_motor_request && !cmd.first_motor_request)
      state_d.sel = motor_switch_pkg::SEL_SECOND;
    // one enum selects both, so both can never be on; break before make
    state_d.out.first_contactor_out = (state_d.sel == motor_switch_pkg::SEL_FIRST)
                                      && !field_in.second_motor_linked_in;
    state_d.out.second_contactor_out = (state_d.sel == motor_switch_pkg::SEL_SECOND)
                                       && !field_in.first_motor_linked_in;

    // motor control step
    linked = (state_d.out.first_contactor_out && field_in.first_motor_linked_in)
             || (state_d.out.second_contactor_out && field_in.second_motor_linked_in);

    // external fault latch, set wins over clear
    if (cmd.alarm_clear_cmd && !cmd.external_fault_in)
      state_d.st.external_fault_alarm = 1'b0;
    if (cmd.alarm_clear_cmd)
      state_d.st.run_feedback_timeout_alarm = 1'b0;
    if (cmd.external_fault_in)
      state_d.st.external_fault_alarm = 1'b1;

    // feedback supervision; counts whole seconds, so up to one tick early
    if (state_q.sup_en && state_q.dir != motor_switch_pkg::DIR_NONE
        && !field_in.drive_running_in) begin
      if (state_q.fb_cnt >= state_q.fb_wait)
        state_d.st.run_feedback_timeout_alarm = 1'b1;
      else if (tick)
        state_d.fb_cnt = state_q.fb_cnt + 16'h1;
    end else begin
      state_d.fb_cnt = 16'h0;
    end
    state_d.st.fault_latched_flag = state_d.st.external_fault_alarm
                                    || state_d.st.run_feedback_timeout_alarm;
    state_d.st.interlock_alert = cmd.external_interlock;

    blocked = cmd.external_interlock || state_q.st.fault_latched_flag
              || op == motor_switch_pkg::OP_BAD || !linked
              || !field_in.breaker_powered_in || !field_in.drive_healthy_in;

    // latched run; halt beats start, mode change forgets the latch
    if (blocked || op != state_q.op) begin
      state_d.latch = motor_switch_pkg::DIR_NONE;
    end else if (op == motor_switch_pkg::OP_MANUAL) begin
      if (cmd.manual_halt_cmd)
        state_d.latch = motor_switch_pkg::DIR_NONE;
      else if (cmd.manual_latch_forward && !cmd.manual_latch_reverse)
        state_d.latch = motor_switch_pkg::DIR_FWD;
      else if (cmd.manual_latch_reverse && !cmd.manual_latch_forward)
        state_d.latch = motor_switch_pkg::DIR_REV;
    end else if (op == motor_switch_pkg::OP_LOCAL) begin
      if (cmd.local_halt_cmd)
        state_d.latch = motor_switch_pkg::DIR_NONE;
      else if (cmd.local_latch_forward && !cmd.local_latch_reverse)
        state_d.latch = motor_switch_pkg::DIR_FWD;
      else if (cmd.local_latch_reverse && !cmd.local_latch_forward)
        state_d.latch = motor_switch_pkg::DIR_REV;
    end

    // jog in auto: both held means neither
    if (cmd.auto_jog_forward && !cmd.auto_jog_reverse)
      jog = motor_switch_pkg::DIR_FWD;
    else if (cmd.auto_jog_reverse && !cmd.auto_jog_forward)
      jog = motor_switch_pkg::DIR_REV;
    else
      jog = motor_switch_pkg::DIR_NONE;

    if (blocked)
      want = motor_switch_pkg::DIR_NONE;
    else if (op == motor_switch_pkg::OP_AUTO)
      want = jog;
    else
      want = state_d.latch;

    // a reversal first drops the run, then waits out the delay
    if (want != motor_switch_pkg::DIR_NONE && want != state_q.last_dir
        && state_q.rev_cnt != 16'h0)
      want = motor_switch_pkg::DIR_NONE;
    if (state_q.dir != motor_switch_pkg::DIR_NONE && want != state_q.dir)
      want = motor_switch_pkg::DIR_NONE;
    state_d.dir = want;
    if (state_q.dir != motor_switch_pkg::DIR_NONE && want == motor_switch_pkg::DIR_NONE) begin
      state_d.rev_cnt = state_q.rev_wait;
      state_d.last_dir = state_q.dir;
    end else if (tick && state_q.rev_cnt != 16'h0) begin
      state_d.rev_cnt = state_q.rev_cnt - 16'h1;
    end

    unique case (op)
      motor_switch_pkg::OP_AUTO:   fast_req = cmd.auto_high_speed_req;
      motor_switch_pkg::OP_MANUAL: fast_req = cmd.manual_high_speed_req;
      motor_switch_pkg::OP_LOCAL:  fast_req = cmd.local_high_speed_req;
      default:                     fast_req = 1'b0;
    endcase
    state_d.out.drive_forward_out = (want == motor_switch_pkg::DIR_FWD);
    state_d.out.drive_reverse_out = (want == motor_switch_pkg::DIR_REV);
    state_d.out.drive_second_preset_out = fast_req
                                          && want != motor_switch_pkg::DIR_NONE;
    state_d.out.drive_fault_clear_out = cmd.alarm_clear_cmd
                                        && !field_in.drive_healthy_in;

    // axi-lite write: address and data in either order, answer after both
    aw_fire = s_axi_awvalid && s_axi_awready;
    w_fire = s_axi_wvalid && s_axi_wready;
    if (aw_fire) begin
      state_d.aw_hold = 1'b1;
      state_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (w_fire) begin
      state_d.w_hold = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
    end
    wr_addr = state_d.aw_addr;
    wr_data = state_d.w_data;
    wr_strb = state_d.w_strb;
    if (state_d.aw_hold && state_d.w_hold && !state_q.bvalid) begin
      state_d.aw_hold = 1'b0;
      state_d.w_hold = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = `RESP_OKAY;
      unique case (wr_addr)
        `REG_CTRL: begin
          if (wr_strb[0])
            state_d.sup_en = wr_data[`CTRL_SUP_EN_BIT];
        end
        `REG_FB_WAIT: begin
          if (wr_strb[0]) state_d.fb_wait[7:0] = wr_data[7:0];
          if (wr_strb[1]) state_d.fb_wait[15:8] = wr_data[15:8];
        end
        `REG_REV_WAIT: begin
          if (wr_strb[0]) state_d.rev_wait[7:0] = wr_data[7:0];
          if (wr_strb[1]) state_d.rev_wait[15:8] = wr_data[15:8];
        end
        default: state_d.bresp = `RESP_SLVERR;
      endcase
    end else if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end

    // axi-lite read; status is read only and shows live flags
    ar_fire = s_axi_arvalid && s_axi_arready;
    if (ar_fire) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = `RESP_OKAY;
      state_d.rdata = 32'h0;
      unique case (s_axi_araddr[7:0])
        `REG_CTRL:     state_d.rdata[`CTRL_SUP_EN_BIT] = state_q.sup_en;
        `REG_FB_WAIT:  state_d.rdata[15:0] = state_q.fb_wait;
        `REG_REV_WAIT: state_d.rdata[15:0] = state_q.rev_wait;
        `REG_STATUS:   state_d.rdata[9:0] = state_q.st;
        default:       state_d.rresp = `RESP_SLVERR;
      endcase
    end else if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
  end

  // synchronous reset clears latches, selections, timers and alarms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
      state_q.sup_en <= `SUP_EN_RST;
      state_q.fb_wait <= `FB_WAIT_RST;
      state_q.rev_wait <= `REV_WAIT_RST;
      state_q.st.local_active_flag <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  contactors_exclusive_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(field_out.first_contactor_out && field_out.second_contactor_out))
    else $error("both contactor outputs active");

  interlock_blocks_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cmd.external_interlock |=> status.interlock_alert
      && !field_out.drive_forward_out && !field_out.drive_reverse_out)
    else $error("interlock did not stop the drive");

  fault_latches_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    status.external_fault_alarm && !cmd.alarm_clear_cmd
      |=> status.external_fault_alarm && status.fault_latched_flag)
    else $error("fault state left without clear");

  fault_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cmd.alarm_clear_cmd && !cmd.external_fault_in
      |=> !status.external_fault_alarm && !status.first_motor_select_alarm)
    else $error("alarm clear did not clear");

  bad_mode_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cmd.auto_op_select && cmd.manual_op_select
      |=> status.bad_op_selection_alarm && !status.auto_active_flag
        && !field_out.drive_forward_out)
    else $error("bad mode not flagged");

  auto_jog_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cmd.auto_op_select && !cmd.manual_op_select && !cmd.auto_jog_forward
      |=> !field_out.drive_forward_out)
    else $error("auto forward ran without jog");

  manual_halt_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    cmd.manual_op_select && !cmd.auto_op_select && cmd.manual_halt_cmd
      ##1 !cmd.manual_latch_forward [*2]
      |=> !field_out.drive_forward_out)
    else $error("manual halt did not end run");

  reversal_wait_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(field_out.drive_forward_out) && state_q.rev_wait != 16'h0
      |-> !field_out.drive_reverse_out [*2])
    else $error("reversed without delay");

  fast_needs_run_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    field_out.drive_second_preset_out
      |-> field_out.drive_forward_out || field_out.drive_reverse_out)
    else $error("fast speed without run");

  no_link_idle_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !field_out.first_contactor_out && !field_out.second_contactor_out
      |-> !field_out.drive_forward_out && !field_out.drive_reverse_out)
    else $error("drive ran with no motor linked");

  select_busy_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    field_out.drive_forward_out && cmd.second_motor_request
      && state_q.sel == motor_switch_pkg::SEL_FIRST
      |=> state_q.sel == motor_switch_pkg::SEL_FIRST && status.second_motor_select_alarm)
    else $error("running motor was deselected");

endmodule
`default_nettype wire

// File: logic/motor_switch_cfg.svh
// register map, field positions, reset values and timing for the motor switch
`ifndef MOTOR_SWITCH_CFG_SVH
`define MOTOR_SWITCH_CFG_SVH

// clock rate and the seconds tick
`define CLK_HZ          10000000
`define TICK_S          1

// register byte offsets
`define REG_CTRL        8'h00
`define REG_FB_WAIT     8'h04
`define REG_REV_WAIT    8'h08
`define REG_STATUS      8'h0c

// field positions
`define CTRL_SUP_EN_BIT 0
`define WAIT_W          16

// reset values
`define SUP_EN_RST      1'b0
`define FB_WAIT_RST     16'h0002
`define REV_WAIT_RST    16'h0002

// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: logic/motor_switch_pkg.sv
// types shared by the two-motor drive switch control
package motor_switch_pkg;

  typedef enum logic [1:0] {SEL_NONE, SEL_FIRST, SEL_SECOND} motor_sel_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_FWD, DIR_REV} dir_t;
  typedef enum logic [1:0] {OP_LOCAL, OP_AUTO, OP_MANUAL, OP_BAD} op_t;

  typedef struct packed {
    logic auto_op_select;
    logic manual_op_select;
    logic auto_jog_forward;
    logic auto_jog_reverse;
    logic local_latch_forward;
    logic local_latch_reverse;
    logic local_halt_cmd;
    logic manual_latch_forward;
    logic manual_latch_reverse;
    logic manual_halt_cmd;
    logic auto_high_speed_req;
    logic local_high_speed_req;
    logic manual_high_speed_req;
    logic first_motor_request;
    logic second_motor_request;
    logic alarm_clear_cmd;
    logic external_interlock;
    logic external_fault_in;
  } cmd_t;

  typedef struct packed {
    logic breaker_powered_in;
    logic drive_healthy_in;
    logic drive_running_in;
    logic first_motor_linked_in;
    logic second_motor_linked_in;
  } field_in_t;

  typedef struct packed {
    logic drive_forward_out;
    logic drive_reverse_out;
    logic drive_fault_clear_out;
    logic drive_second_preset_out;
    logic first_contactor_out;
    logic second_contactor_out;
  } field_out_t;

  typedef struct packed {
    logic auto_active_flag;
    logic manual_active_flag;
    logic local_active_flag;
    logic fault_latched_flag;
    logic interlock_alert;
    logic bad_op_selection_alarm;
    logic external_fault_alarm;
    logic run_feedback_timeout_alarm;
    logic first_motor_select_alarm;
    logic second_motor_select_alarm;
  } status_t;

  typedef struct packed {
    motor_sel_t  sel;
    dir_t        latch;
    dir_t        dir;
    dir_t        last_dir;
    op_t         op;
    logic [15:0] rev_cnt;
    logic [15:0] fb_cnt;
    logic [31:0] presc;
    logic        sup_en;
    logic [15:0] fb_wait;
    logic [15:0] rev_wait;
    field_out_t  out;
    status_t     st;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

endpackage

// File: bench/drive_model.sv
// behavioural drive, contactors and breaker on the field side
`timescale 1ns/10ps
`default_nettype none
module drive_model (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire motor_switch_pkg::field_out_t field_out,
  input  wire logic                         stall_run,
  input  wire logic                         drive_fault,
  output var motor_switch_pkg::field_in_t   field_in
);
  // contacts follow their commands one cycle late, as a relay would
  always @(posedge aclk) begin
    if (!aresetn) begin
      field_in <= '0;
    end else begin
      field_in.breaker_powered_in <= 1'h1;
      field_in.drive_healthy_in <= !drive_fault;
      field_in.drive_running_in <= (field_out.drive_forward_out | field_out.drive_reverse_out)
                                   & !stall_run;
      field_in.first_motor_linked_in <= field_out.first_contactor_out;
      field_in.second_motor_linked_in <= field_out.second_contactor_out;
    end
  end
endmodule
`default_nettype wire

// File: bench/dual_motor_drive_switch_control_tb_top.sv
// self-checking bench for the two-motor drive switch control
`timescale 1ns/10ps
`default_nettype none
module dual_motor_drive_switch_control_tb_top;
  localparam motor_switch_pkg::cmd_t CLR = '{alarm_clear_cmd: 1'h1, default: 1'h0};
  localparam motor_switch_pkg::cmd_t MFWD = '{manual_latch_forward: 1'h1, default: 1'h0};
  localparam motor_switch_pkg::cmd_t MHALT = '{manual_halt_cmd: 1'h1, default: 1'h0};
  localparam motor_switch_pkg::cmd_t LFWD = '{local_latch_forward: 1'h1, default: 1'h0};
  localparam motor_switch_pkg::cmd_t LREV = '{local_latch_reverse: 1'h1, default: 1'h0};
  localparam motor_switch_pkg::cmd_t LHALT = '{local_halt_cmd: 1'h1, default: 1'h0};
  localparam motor_switch_pkg::cmd_t REQ1 = '{first_motor_request: 1'h1, default: 1'h0};
  localparam motor_switch_pkg::cmd_t REQ2 = '{second_motor_request: 1'h1, default: 1'h0};
  logic                          aclk = 1'h0;
  logic                          aresetn = 1'h0;
  logic [7:0]                    awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]                   wdata = 32'h0, rdata, d;
  logic                          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic                          arvalid = 1'h0, rready = 1'h0, stall = 1'h0, dfault = 1'h0;
  logic                          awready, wready, bvalid, arready, rvalid;
  logic [1:0]                    bresp, rresp, r;
  motor_switch_pkg::cmd_t        c = '0;
  motor_switch_pkg::field_in_t   fi;
  motor_switch_pkg::field_out_t  fo;
  motor_switch_pkg::status_t     st;
  int                            errors = 0, n_checks = 0;

  always #50 aclk = ~aclk;

  // short tick keeps the 2 s waits at about 20 cycles
  motor_switch #(.TICK_CYCLES(10), .ADDR_W(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd(c), .field_in(fi), .field_out(fo), .status(st));

  drive_model i_far (.aclk(aclk), .aresetn(aresetn), .field_out(fo), .stall_run(stall),
    .drive_fault(dfault), .field_in(fi));

  task go(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task look;
    @(negedge aclk);
  endtask
  task pulse(input motor_switch_pkg::cmd_t m);
    go(1);
    c <= c | m;
    go(1);
    c <= c & ~m;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // handshakes judged at the falling edge, where they equal what the next rising edge sees
  task axw(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    int   k;
    go(1);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 100; k++) begin
      look;
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      go(1);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      if (b) break;
    end
    bready <= 1'h0;
    if (k == 100) errors++;
  endtask
  task axr(input logic [7:0] a);
    logic ar, b;
    int   k;
    go(1);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 100; k++) begin
      look;
      ar = arvalid && arready;
      b = rvalid;
      d = rdata;
      r = rresp;
      go(1);
      if (ar) arvalid <= 1'h0;
      if (b) break;
    end
    rready <= 1'h0;
    if (k == 100) errors++;
  endtask
  task conclude;
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #2000000;
    errors++;
    conclude();
  end

  initial begin
    go(4);
    aresetn <= 1'h1;
    axr(8'h00);
    chk(d, 32'h0);
    axr(8'h04);
    chk(d, 32'h2);
    axr(8'h08);
    chk(d, 32'h2);
    axr(8'h0c);
    chk(d, 32'h80);
    axr(8'h40);
    chk(r, 2'h2);
    axw(8'h0c, 32'h0);
    chk(r, 2'h2);
    pulse(REQ2);
    go(3);
    look;
    chk({fo.first_contactor_out, fo.second_contactor_out}, 2'h1);
    go(1);
    c.manual_op_select <= 1'h1;
    c.manual_high_speed_req <= 1'h1;
    pulse(MFWD);
    go(3);
    look;
    chk({st.manual_active_flag, fo.drive_forward_out, fo.drive_second_preset_out},
        3'h7);
    pulse(REQ1);
    go(2);
    look;
    chk({st.first_motor_select_alarm, fo.first_contactor_out, fo.second_contactor_out},
        3'h5);
    go(1);
    c.manual_high_speed_req <= 1'h0;
    pulse(MHALT);
    go(2);
    look;
    chk(fo.drive_forward_out, 1'h0);
    pulse(CLR);
    look;
    chk(st.first_motor_select_alarm, 1'h0);
    pulse(REQ1);
    go(6);
    look;
    chk({fo.first_contactor_out, fo.second_contactor_out}, 2'h2);
    pulse(CLR);
    go(1);
    c.auto_op_select <= 1'h1;
    go(3);
    look;
    chk(st.bad_op_selection_alarm, 1'h1);
    go(1);
    c.manual_op_select <= 1'h0;
    pulse(CLR);
    look;
    chk({st.auto_active_flag, st.bad_op_selection_alarm}, 2'h2);
    go(1);
    c.auto_jog_forward <= 1'h1;
    go(4);
    look;
    chk(fo.drive_forward_out, 1'h1);
    go(1);
    c.auto_jog_forward <= 1'h0;
    c.auto_jog_reverse <= 1'h1;
    c.auto_high_speed_req <= 1'h1;
    go(8);
    look;
    chk(fo.drive_reverse_out, 1'h0);
    go(45);
    look;
    chk({fo.drive_reverse_out, fo.drive_second_preset_out}, 2'h3);
    go(1);
    c.auto_jog_reverse <= 1'h0;
    c.auto_high_speed_req <= 1'h0;
    go(3);
    look;
    chk(fo.drive_reverse_out, 1'h0);
    go(50);
    c.auto_jog_forward <= 1'h1;
    go(4);
    pulse(REQ2);
    go(1);
    look;
    chk({st.second_motor_select_alarm, fo.first_contactor_out}, 2'h3);
    go(1);
    c.external_interlock <= 1'h1;
    go(3);
    look;
    chk({st.interlock_alert, fo.drive_forward_out}, 2'h2);
    go(1);
    c.external_interlock <= 1'h0;
    c.auto_jog_forward <= 1'h0;
    c.external_fault_in <= 1'h1;
    go(1);
    c.external_fault_in <= 1'h0;
    go(3);
    look;
    chk({st.fault_latched_flag, st.external_fault_alarm}, 2'h3);
    pulse(CLR);
    look;
    chk({st.fault_latched_flag, st.external_fault_alarm}, 2'h0);
    go(1);
    dfault <= 1'h1;
    go(2);
    pulse(CLR);
    look;
    chk(fo.drive_fault_clear_out, 1'h1);
    go(1);
    dfault <= 1'h0;
    c.auto_op_select <= 1'h0;
    c.local_high_speed_req <= 1'h1;
    go(2);
    pulse(LFWD);
    go(2);
    look;
    chk({st.local_active_flag, fo.drive_forward_out, fo.drive_second_preset_out},
        3'h7);
    pulse(LHALT);
    look;
    chk(fo.drive_forward_out, 1'h0);
    axw(8'h00, 32'h1);
    chk(r, 2'h0);
    go(1);
    stall <= 1'h1;
    pulse(LFWD);
    go(45);
    look;
    chk({st.run_feedback_timeout_alarm, fo.drive_forward_out}, 2'h2);
    go(1);
    stall <= 1'h0;
    pulse(CLR);
    look;
    chk(st.run_feedback_timeout_alarm, 1'h0);
    pulse(LREV);
    go(2);
    look;
    chk(fo.drive_reverse_out, 1'h1);
    pulse(LHALT);
    pulse(LFWD);
    go(3);
    aresetn <= 1'h0;
    go(2);
    aresetn <= 1'h1;
    look;
    chk({fo.drive_forward_out, fo.first_contactor_out, st.local_active_flag}, 3'h1);
    axr(8'h00);
    chk(d, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
